// *** btb_pkg.sv ***
// Purpose: Shared constants and types for the bit test branch unit
// Assumes: 16-bit data words, 16-bit program counter
// Notes:   Cycle figures are oscillator cycles of the core clock
`default_nettype none
package btb_pkg;
    localparam int unsigned DATA_W         = 16;
    localparam int unsigned ADDR_W         = 16;
    localparam int unsigned OFFS_W         = 7;
    localparam int unsigned SHORT_W        = 6;
    localparam int unsigned REGF_W         = 5;
    localparam logic [7:0]  CYC_FAST_TAKEN = 8'h0a;
    localparam logic [7:0]  CYC_FAST_FALL  = 8'h08;
    localparam logic [7:0]  CYC_SLOW_TAKEN = 8'h0c;
    localparam logic [7:0]  CYC_SLOW_FALL  = 8'h0a;
    localparam logic [1:0]  WORDS_SHORT    = 2'h2;
    localparam logic [1:0]  WORDS_LONG     = 2'h3;
    localparam logic [15:0] IO_BASE        = 16'hffc0;
    localparam logic [4:0]  REG_HW_STACK   = 5'h1f;
    localparam logic [15:0] PC_RESET       = 16'h0000;

    typedef enum logic [2:0]
    {
        MODE_REG,
        MODE_INDEX,
        MODE_STACK,
        MODE_ABS_SHORT,
        MODE_IO_SHORT,
        MODE_ABS_LONG
    } btb_mode_type;

    typedef struct packed
    {
        logic                    all_one_op;
        btb_mode_type            mode;
        logic [DATA_W-1:0]       byte_select_immediate;
        logic [REGF_W-1:0]       register_operand_field;
        logic [SHORT_W-1:0]      short_addr;
        logic [ADDR_W-1:0]       long_addr;
        logic [OFFS_W-1:0]       branch_offset_field;
    } btb_instr_type;

    typedef struct packed
    {
        logic              valid;
        logic              carry;
        logic              limit;
        logic              taken;
        logic [ADDR_W-1:0] pc;
    } btb_result_type;
endpackage : btb_pkg
`default_nettype wire

// *** btb_unit.sv ***
// Behaviour
// RQ1: All-zero op: masked bits all clear sets carry and branches.
// RQ2: All-zero op: any masked bit one clears carry, falls through.
// RQ3: All-one op: masked bits all set sets carry and branches.
// RQ4: All-one op: any masked bit zero clears carry, falls through.
// RQ5: Tested bits chosen by eight-bit mask, one bit selects.
// RQ6: Mask is 16-bit with one byte all zero; one lane tested.
// RQ7: Empty mask sets carry and branches unconditionally.
// RQ8: Taken branch loads PC plus displacement.
// RQ9: Displacement is a 7-bit PC-relative field.
// RQ10: Displacement sign-extended; PC already points past the instruction.
// RQ11: Limit bit set when a saturating accumulator move feeds the test.
// RQ12: Any register operand allowed except the hardware return stack.
// RQ13: Six operand forms: register, indexed, stack, short, io, long.
// RQ14: Absolute short form carries a 6-bit data address.
// RQ15: I/O short form carries a 6-bit peripheral address.
// RQ16: Taken costs 10 fast-form cycles, 12 slow-form cycles.
// RQ17: Not taken costs 8 fast-form cycles, 10 slow-form cycles.
// RQ18: Two program words, three for absolute long.
// Purpose: Executes the two bit-test-and-branch instructions
// Assumes: Memory answers combinationally while o_mem_rd is high; one issue at a time
// Notes:   o_done pulses when the instruction's full cycle budget has elapsed
`timescale 1ns/1ps
`default_nettype none
module btb_unit
    import btb_pkg::*;
(
    input  wire logic                i_clk_sys,
    input  wire logic                i_rst,
    input  wire logic                i_start,
    input  wire btb_instr_type       i_instr,
    input  wire logic [ADDR_W-1:0]   i_pc,
    input  wire logic [ADDR_W-1:0]   i_index_pointer_two,
    input  wire logic [ADDR_W-1:0]   i_stack_ptr,
    input  wire logic [DATA_W-1:0]   i_reg_data,
    input  wire logic                i_reg_limited,
    input  wire logic [DATA_W-1:0]   i_mem_data,
    output logic                     o_busy,
    output logic [REGF_W-1:0]        o_reg_sel,
    output logic                     o_mem_rd,
    output logic                     o_mem_io,
    output logic [ADDR_W-1:0]        o_mem_addr,
    output logic                     o_illegal,
    output logic [1:0]               o_words,
    output logic                     o_done,
    output btb_result_type           o_result
);
    typedef enum logic [1:0] {S_IDLE, S_FETCH, S_WAIT} btb_state_type;

    function automatic logic btb_slow(input btb_mode_type m);
        btb_slow = (m == MODE_INDEX) || (m == MODE_STACK) || (m == MODE_ABS_LONG);
    endfunction : btb_slow

    function automatic logic btb_hws(input btb_instr_type ins);
        btb_hws = (ins.mode == MODE_REG) && (ins.register_operand_field == REG_HW_STACK);
    endfunction : btb_hws

    function automatic logic [1:0] btb_words(input btb_mode_type m);
        btb_words = (m == MODE_ABS_LONG) ? WORDS_LONG : WORDS_SHORT;
    endfunction : btb_words

    btb_state_type      state_ff;
    btb_instr_type      instr_ff;
    logic [ADDR_W-1:0]  pc_ff;
    logic [7:0]         cnt_ff;
    logic [7:0]         nxt_cnt;
    logic [DATA_W-1:0]  opnd;
    logic               lim;
    logic               pass;
    logic [ADDR_W-1:0]  offs;
    logic [ADDR_W-1:0]  ea;
    logic [1:0]         words;
    logic               busy;

    assign busy   = (state_ff != S_IDLE);
    assign o_busy = busy;
    assign words  = btb_words(instr_ff.mode); // RQ18
    assign o_words = words;

    // Effective address of the memory forms
    always_comb
    begin
        case (instr_ff.mode) // RQ13
            MODE_INDEX:     ea = i_index_pointer_two + {{(ADDR_W-SHORT_W){1'b0}}, instr_ff.short_addr};
            MODE_STACK:     ea = i_stack_ptr - {{(ADDR_W-SHORT_W){1'b0}}, instr_ff.short_addr};
            MODE_ABS_SHORT: ea = {{(ADDR_W-SHORT_W){1'b0}}, instr_ff.short_addr}; // RQ14
            MODE_IO_SHORT:  ea = IO_BASE | {{(ADDR_W-SHORT_W){1'b0}}, instr_ff.short_addr}; // RQ15
            MODE_ABS_LONG:  ea = instr_ff.long_addr;
            default:        ea = '0;
        endcase
    end

    assign o_reg_sel  = instr_ff.register_operand_field;
    assign o_mem_rd   = (state_ff == S_FETCH) && (instr_ff.mode != MODE_REG);
    assign o_mem_io   = (instr_ff.mode == MODE_IO_SHORT);
    assign o_mem_addr = ea;

    assign opnd = (instr_ff.mode == MODE_REG) ? i_reg_data : i_mem_data;
    assign lim  = (instr_ff.mode == MODE_REG) && i_reg_limited; // RQ11

    // Empty mask passes both ops; the full 16-bit mask is applied, both lanes together
    always_comb
    begin
        if (instr_ff.all_one_op)
            pass = ((opnd & instr_ff.byte_select_immediate) == instr_ff.byte_select_immediate); // RQ3 RQ4 RQ5 RQ6 RQ7
        else
            pass = ((opnd & instr_ff.byte_select_immediate) == '0); // RQ1 RQ2 RQ5 RQ6 RQ7
    end

    assign offs = {{(ADDR_W-OFFS_W){instr_ff.branch_offset_field[OFFS_W-1]}},
                   instr_ff.branch_offset_field}; // RQ9 RQ10

    always_comb
    begin
        if (btb_slow(instr_ff.mode))
            nxt_cnt = pass ? CYC_SLOW_TAKEN : CYC_SLOW_FALL; // RQ16 RQ17
        else
            nxt_cnt = pass ? CYC_FAST_TAKEN : CYC_FAST_FALL; // RQ16 RQ17
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            instr_ff <= '0;
        else if (!busy && i_start)
            instr_ff <= i_instr;
    end

    // PC of the following instruction, captured at issue
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            pc_ff <= PC_RESET;
        else if (!busy && i_start)
            pc_ff <= i_pc + {14'h0000, btb_words(i_instr.mode)}; // RQ10 RQ18
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            o_illegal <= 1'b0;
        else if (!busy && i_start)
            o_illegal <= btb_hws(i_instr); // RQ12
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_ff <= S_IDLE;
            cnt_ff   <= 8'h00;
        end
        else
        begin
            case (state_ff)
                S_IDLE:
                    if (i_start && !btb_hws(i_instr)) // RQ12
                        state_ff <= S_FETCH;
                S_FETCH:
                begin
                    state_ff <= S_WAIT;
                    cnt_ff   <= nxt_cnt - 8'h02;
                end
                S_WAIT:
                    if (cnt_ff == 8'h00)
                        state_ff <= S_IDLE;
                    else
                        cnt_ff <= cnt_ff - 8'h01;
                default:
                    state_ff <= S_IDLE;
            endcase
        end
    end

    // Result captured at the test; published at completion
    btb_result_type res_ff;
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            res_ff <= '0;
        else if (state_ff == S_FETCH)
        begin
            res_ff.valid <= 1'b0;
            res_ff.carry <= pass; // RQ1 RQ2 RQ3 RQ4
            res_ff.limit <= lim; // RQ11
            res_ff.taken <= pass;
            res_ff.pc    <= pass ? pc_ff + offs : pc_ff; // RQ8
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_done   <= 1'b0;
            o_result <= '0;
        end
        else
        begin
            o_done <= (state_ff == S_WAIT) && (cnt_ff == 8'h00);
            if ((state_ff == S_WAIT) && (cnt_ff == 8'h00))
            begin
                o_result       <= res_ff;
                o_result.valid <= 1'b1;
            end
            else
                o_result.valid <= 1'b0;
        end
    end

    // Legal issue, then the test cycle with its cycle budget
    sequence s_legal_issue;
        !busy && i_start && !btb_hws(i_instr);
    endsequence

    sequence s_test_cycle(n);
        (state_ff == S_FETCH) && (nxt_cnt == n);
    endsequence

    property p_budget(n);
        @(posedge i_clk_sys) disable iff (i_rst)
        s_test_cycle(n) |-> ##(n) o_done;
    endproperty

    a_fast_taken_time: assert property (p_budget(10)) else $error("taken fast timing"); // RQ16
    a_fall_time: assert property (p_budget(8)) else $error("fall fast timing"); // RQ17
    a_slow_taken_time: assert property (p_budget(12)) else $error("slow timing"); // RQ16

    a_no_early_done: assert property ( // RQ17
        @(posedge i_clk_sys) disable iff (i_rst)
        (state_ff == S_FETCH) |=> (!o_done) [*7])
        else $error("done before budget");
    a_done_pulse: assert property ( // RQ16
        @(posedge i_clk_sys) disable iff (i_rst)
        o_done |=> !o_done)
        else $error("done longer than one cycle");

    a_issue_fetch: assert property ( // RQ13
        @(posedge i_clk_sys) disable iff (i_rst)
        s_legal_issue |=> (state_ff == S_FETCH) && (o_mem_rd == (instr_ff.mode != MODE_REG)))
        else $error("operand fetch missing");
    a_fetch_once: assert property ( // RQ13
        @(posedge i_clk_sys) disable iff (i_rst)
        o_mem_rd |=> !o_mem_rd)
        else $error("operand fetched twice");
    a_next_pc: assert property ( // RQ10 RQ18
        @(posedge i_clk_sys) disable iff (i_rst)
        s_legal_issue |=> pc_ff == $past(i_pc) + {14'h0000, o_words})
        else $error("following pc wrong");

    a_clear_hit: assert property ( // RQ1 RQ5
        @(posedge i_clk_sys) disable iff (i_rst)
        (state_ff == S_FETCH) && !instr_ff.all_one_op &&
        !(|(opnd & instr_ff.byte_select_immediate)) |=> res_ff.carry && res_ff.taken)
        else $error("clear test missed");
    a_clear_miss: assert property ( // RQ2
        @(posedge i_clk_sys) disable iff (i_rst)
        (state_ff == S_FETCH) && !instr_ff.all_one_op &&
        (|(opnd & instr_ff.byte_select_immediate)) |=> !res_ff.carry && !res_ff.taken)
        else $error("clear test false hit");
    a_set_hit: assert property ( // RQ3 RQ5
        @(posedge i_clk_sys) disable iff (i_rst)
        (state_ff == S_FETCH) && instr_ff.all_one_op &&
        (&(opnd | ~instr_ff.byte_select_immediate)) |=> res_ff.carry && res_ff.taken)
        else $error("set test missed");
    a_set_miss: assert property ( // RQ4
        @(posedge i_clk_sys) disable iff (i_rst)
        (state_ff == S_FETCH) && instr_ff.all_one_op &&
        !(&(opnd | ~instr_ff.byte_select_immediate)) |=> !res_ff.carry && !res_ff.taken)
        else $error("set test false hit");

    a_limit_flag: assert property ( // RQ11
        @(posedge i_clk_sys) disable iff (i_rst)
        (state_ff == S_FETCH) && (instr_ff.mode == MODE_REG) && i_reg_limited |=> res_ff.limit)
        else $error("limit not reported");
    a_limit_mem: assert property ( // RQ11
        @(posedge i_clk_sys) disable iff (i_rst)
        (state_ff == S_FETCH) && (instr_ff.mode != MODE_REG) |=> !res_ff.limit)
        else $error("limit from memory operand");

    a_short_addr: assert property ( // RQ14
        @(posedge i_clk_sys) disable iff (i_rst)
        o_mem_rd && (instr_ff.mode == MODE_ABS_SHORT) |->
        (o_mem_addr[ADDR_W-1:SHORT_W] == '0) && !o_mem_io)
        else $error("short address out of range");
    a_io_addr: assert property ( // RQ15
        @(posedge i_clk_sys) disable iff (i_rst)
        o_mem_rd && (instr_ff.mode == MODE_IO_SHORT) |->
        o_mem_io && (o_mem_addr[ADDR_W-1:SHORT_W] == IO_BASE[ADDR_W-1:SHORT_W]))
        else $error("io address out of range");

    a_taken_target: assert property ( // RQ8
        @(posedge i_clk_sys) disable iff (i_rst)
        o_done && o_result.taken |-> o_result.pc == pc_ff + offs)
        else $error("bad branch target");
    a_carry_taken: assert property ( // RQ1 RQ3
        @(posedge i_clk_sys) disable iff (i_rst)
        o_done && (offs != '0) |-> o_result.carry == (o_result.pc != pc_ff))
        else $error("carry and branch disagree");
    a_fall_pc: assert property ( // RQ2
        @(posedge i_clk_sys) disable iff (i_rst)
        o_done && !o_result.taken |-> o_result.pc == pc_ff)
        else $error("fall through pc wrong");
    a_empty_mask_pass: assert property ( // RQ7
        @(posedge i_clk_sys) disable iff (i_rst)
        (state_ff == S_FETCH) && (instr_ff.byte_select_immediate == '0) |-> pass)
        else $error("empty mask not taken");
    a_hws_refused: assert property ( // RQ12
        @(posedge i_clk_sys) disable iff (i_rst)
        !busy && i_start && btb_hws(i_instr) |=> !busy && o_illegal)
        else $error("hardware stack accepted");
    a_word_count: assert property ( // RQ18
        @(posedge i_clk_sys) disable iff (i_rst)
        busy |-> o_words == ((instr_ff.mode == MODE_ABS_LONG) ? 2'h3 : 2'h2))
        else $error("word count wrong");
endmodule : btb_unit
`default_nettype wire

// *** btb_mem_model.sv ***
// Purpose: Data memory and peripheral I/O space model for the bit test unit
// Assumes: Read data answers combinationally while o_mem_rd is high
// Notes:   Idle bus shows the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module btb_mem_model
    import btb_pkg::*;
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_rd,
    input  wire logic [ADDR_W-1:0] i_addr,
    output logic [DATA_W-1:0]      o_data
);
    logic [DATA_W-1:0] mem [64];
    logic [DATA_W-1:0] last_ff = 16'h0000;

    // Low six address bits pick the cell for index, stack, short, io and long forms
    assign o_data = i_rd ? mem[i_addr[5:0]] : ~last_ff;

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rd)
            last_ff <= o_data;
    end
endmodule : btb_mem_model
`default_nettype wire

// *** tb.sv ***
// Purpose: Self-checking bench for the bit test branch unit
// Assumes: Cycle counts taken from the issue edge to the done pulse
// Notes:   Illegal register case runs last
`timescale 1ns/1ps
`default_nettype none
module tb;
    import btb_pkg::*;
    logic           clk_sys = 1'b0;
    logic           rst = 1'b1;
    logic           start = 1'b0;
    btb_instr_type  instr = '0;
    logic [15:0]    pc = 16'h0000;
    logic [15:0]    reg_data = 16'h0000;
    logic           reg_lim = 1'b0;
    logic [15:0]    mem_data;
    logic           busy;
    logic [4:0]     reg_sel;
    logic           mem_rd;
    logic           mem_io;
    logic [15:0]    mem_addr;
    logic           illegal;
    logic [1:0]     words;
    logic           done;
    btb_result_type result;
    int             err_count = 0;
    int             check_count = 0;

    always #2 clk_sys = ~clk_sys;

    btb_mem_model i_btb_mem_model (.i_clk_sys(clk_sys), .i_rd(mem_rd), .i_addr(mem_addr),
        .o_data(mem_data));

    btb_unit i_btb_unit (.i_clk_sys(clk_sys), .i_rst(rst), .i_start(start), .i_instr(instr),
        .i_pc(pc), .i_index_pointer_two(16'h0040), .i_stack_ptr(16'h0080),
        .i_reg_data(reg_data), .i_reg_limited(reg_lim), .i_mem_data(mem_data),
        .o_busy(busy), .o_reg_sel(reg_sel), .o_mem_rd(mem_rd), .o_mem_io(mem_io),
        .o_mem_addr(mem_addr), .o_illegal(illegal), .o_words(words), .o_done(done),
        .o_result(result));

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic run(input logic op, input int m, input logic [15:0] mask,
                       input logic [15:0] val, input logic [6:0] off, input logic lim);
        btb_instr_type ins;
        int            cyc;
        int            n;
        logic          tk;
        logic [1:0]    w;
        logic [15:0]   nx;
        ins = '0;
        ins.all_one_op = op;
        ins.mode = btb_mode_type'(m);
        ins.byte_select_immediate = mask;
        ins.register_operand_field = 5'h03;
        ins.short_addr = 6'h22;
        ins.long_addr = 16'h1234;
        ins.branch_offset_field = off;
        for (int k = 0; k < 64; k++) i_btb_mem_model.mem[k] = val;
        tk = op ? ((val & mask) == mask) : ((val & mask) == 16'h0000);
        w = (m == 5) ? 2'h3 : 2'h2;
        nx = 16'h0100 + {14'h0000, w};
        n = (m == 0 || m == 3 || m == 4) ? (tk ? 10 : 8) : (tk ? 12 : 10);
        @(posedge clk_sys);
        start <= 1'b1;
        instr <= ins;
        pc <= 16'h0100;
        reg_data <= val;
        reg_lim <= lim;
        @(posedge clk_sys);
        start <= 1'b0;
        #1;
        chk("busy", {15'h0000, busy}, 16'h0001);
        chk("words", {14'h0000, words}, {14'h0000, w});
        chk("mem read", {15'h0000, mem_rd}, {15'h0000, m != 0});
        if (m == 0) chk("reg select", {11'h000, reg_sel}, 16'h0003);
        if (m == 3) chk("short addr", mem_addr, 16'h0022);
        if (m == 1) chk("index addr", mem_addr, 16'h0062);
        if (m == 2) chk("stack addr", mem_addr, 16'h005e);
        if (m == 4) chk("io addr", mem_addr, 16'hffe2);
        chk("mem io", {15'h0000, mem_io}, {15'h0000, m == 4});
        if (m == 5) chk("long addr", mem_addr, 16'h1234);
        cyc = 0;
        while (done !== 1'b1 && cyc < 40)
        begin
            @(posedge clk_sys);
            #1;
            cyc++;
        end
        chk("cycles", 16'(cyc), 16'(n));
        chk("carry", {15'h0000, result.carry}, {15'h0000, tk});
        chk("taken", {15'h0000, result.taken}, {15'h0000, tk});
        chk("target", result.pc, tk ? nx + {{9{off[6]}}, off} : nx);
        chk("limit", {15'h0000, result.limit}, {15'h0000, lim && m == 0});
        chk("valid", {15'h0000, result.valid}, 16'h0001);
    endtask : run

    task automatic t_clear_op;
        run(1'b0, 0, 16'h0013, 16'h18ec, 7'h02, 1'b0);
        run(1'b0, 0, 16'h1300, 16'h18ec, 7'h02, 1'b0);
        run(1'b0, 0, 16'h0000, 16'hffff, 7'h40, 1'b0);
        $display("t_clear_op finished");
    endtask : t_clear_op

    task automatic t_set_op;
        run(1'b1, 0, 16'h00f0, 16'h0ff0, 7'h7f, 1'b0);
        run(1'b1, 0, 16'hff00, 16'h0ff0, 7'h02, 1'b0);
        run(1'b1, 0, 16'h0000, 16'h0000, 7'h3f, 1'b0);
        $display("t_set_op finished");
    endtask : t_set_op

    task automatic t_modes;
        for (int m = 0; m < 6; m++)
        begin
            run(1'b0, m, 16'h0013, 16'h18ec, 7'h05, 1'b0);
            run(1'b0, m, 16'h0013, 16'h18ef, 7'h05, 1'b0);
        end
        $display("t_modes finished");
    endtask : t_modes

    task automatic t_limit;
        run(1'b1, 0, 16'h0001, 16'h0001, 7'h01, 1'b1);
        run(1'b1, 3, 16'h0001, 16'h0001, 7'h01, 1'b1);
        $display("t_limit finished");
    endtask : t_limit

    task automatic t_illegal;
        int seen;
        seen = 0;
        @(posedge clk_sys);
        start <= 1'b1;
        instr.mode <= MODE_REG;
        instr.register_operand_field <= 5'h1f;
        @(posedge clk_sys);
        start <= 1'b0;
        #1;
        chk("illegal", {15'h0000, illegal}, 16'h0001);
        chk("idle busy", {15'h0000, busy}, 16'h0000);
        repeat (20)
        begin
            @(posedge clk_sys);
            #1;
            if (done === 1'b1) seen++;
        end
        chk("no done", 16'(seen), 16'h0000);
        $display("t_illegal finished");
    endtask : t_illegal

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test

    initial
    begin
        #20000;
        err_count++;
        stop_test();
    end

    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        t_clear_op();
        t_set_op();
        t_modes();
        t_limit();
        t_illegal();
        stop_test();
    end
endmodule : tb
`default_nettype wire
